// ---- hw/amp_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef AMP_MAP_SVH
`define AMP_MAP_SVH
// register offsets
`define A_OUT_CFG 8'h00
`define A_CTRL1 8'h01
`define A_CHSTATE 8'h0F
`define A_FAULT 8'h10
`define A_CLIPST 8'h13
`define A_ACEN 8'h15
`define A_ACLOOP 8'h16
`define A_PH_HI 8'h1B
`define A_PH_LO 8'h1C
`define A_ST_HI 8'h1D
`define A_ST_LO 8'h1E
`define A_CTRL3 8'h21
`define A_CLIPWIN 8'h23
`define A_ILIM 8'h25
// field positions
`define B_LOOPBACK 7
`define B_SENSE 3
`define B_SENSE_CH2 0
`define B_LIM_LVL 4
`define B_CLEAR 7
`define B_DIAG_EN 4
`define B_ILIM_MASK 5
`define B_CLIP_NONLATCH 2
`define B_CLIP_MASK 1
`define B_DC_MASK 0
// reset values
`define R_CTRL3 8'h10
`define R_CLIPWIN 8'h14
// timing
`define T_CLK_MHZ 100
`define T_RETRY_MS 1000
`define T_DIAG_US 100
`endif

// ---- hw/amp_pkg.sv ----
// state types shared by the amplifier control blocks
package amp_pkg;
  typedef enum logic [1:0] {CH_PLAY = 2'b00, CH_FLT = 2'b01, CH_DIAG = 2'b11,
    CH_WAIT = 2'b10} ch_st_t;
  typedef enum logic [1:0] {AC_IDLE = 2'b00, AC_RUN = 2'b01, AC_HOLD = 2'b11} ac_st_t;
  typedef enum logic [2:0] {I_IDLE = 3'b000, I_ADDR = 3'b001, I_PTR = 3'b011,
    I_WDAT = 3'b010, I_ACK = 3'b110, I_RDAT = 3'b111, I_RACK = 3'b101} i2c_st_t;
endpackage

// ---- hw/sync2.sv ----
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // first and second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sy_t;
  sy_t s_ff;
  sy_t nxt_s;
  // shift the levels one stage along
  always_comb begin
    nxt_s.s1 = d;
    nxt_s.s2 = s_ff.s1;
  end
  // stage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign q = s_ff.s2;
endmodule // sync2

// ---- hw/i2c_target.sv ----
// two-wire register target: pointer byte, auto-increment writes and reads
`timescale 1ns/1ps
module i2c_target import amp_pkg::*; #(
  parameter logic [6:0] ADDR = 7'h35
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rdata,
  output logic [7:0] ptr,
  output logic wr,
  output logic [7:0] wa,
  output logic [7:0] wd,
  output logic sda_oe_n
);
  // whole target state
  typedef struct packed {
    i2c_st_t st;
    i2c_st_t nx;
    logic [7:0] sh;
    logic [3:0] n;
    logic nack;
    logic [7:0] ptr;
    logic oe_n;
    logic scl_d;
    logic sda_d;
    logic wr;
    logic [7:0] wa;
    logic [7:0] wd;
  } it_t;
  it_t s_ff;
  it_t nxt_s;
  logic rise;
  logic fall;
  assign rise = scl && !s_ff.scl_d;
  assign fall = !scl && s_ff.scl_d;
  // bit engine: start and stop win over everything else
  always_comb begin
    nxt_s = s_ff;
    nxt_s.wr = 1'b0;
    nxt_s.scl_d = scl;
    nxt_s.sda_d = sda;
    if (scl && s_ff.scl_d && s_ff.sda_d && !sda) begin
      nxt_s.st = I_ADDR;
      nxt_s.n = '0;
      nxt_s.oe_n = 1'b1;
    end else if (scl && s_ff.scl_d && !s_ff.sda_d && sda) begin
      nxt_s.st = I_IDLE;
      nxt_s.oe_n = 1'b1;
    end else begin
      unique case (s_ff.st)
        I_IDLE: ;
        I_ADDR, I_PTR, I_WDAT: begin
          if (rise) begin
            nxt_s.sh = {s_ff.sh[6:0], sda};
            nxt_s.n = s_ff.n + 4'h1;
          end else if (fall && s_ff.n == 4'h8) begin
            // byte complete: pull the acknowledge bit low
            nxt_s.n = '0;
            nxt_s.st = I_ACK;
            nxt_s.oe_n = 1'b0;
            if (s_ff.st == I_ADDR) begin
              nxt_s.nx = s_ff.sh[0] ? I_RDAT : I_PTR;
              if (s_ff.sh[7:1] != ADDR) begin
                nxt_s.st = I_IDLE;
                nxt_s.oe_n = 1'b1;
              end
            end else if (s_ff.st == I_PTR) begin
              nxt_s.ptr = s_ff.sh;
              nxt_s.nx = I_WDAT;
            end else begin
              nxt_s.wr = 1'b1;
              nxt_s.wa = s_ff.ptr;
              nxt_s.wd = s_ff.sh;
              nxt_s.ptr = s_ff.ptr + 8'h01;
            end
          end
        end
        I_ACK: if (fall) begin
          nxt_s.st = s_ff.nx;
          nxt_s.oe_n = 1'b1;
          if (s_ff.nx == I_RDAT) begin
            nxt_s.sh = rdata;
            nxt_s.oe_n = rdata[7];
            nxt_s.ptr = s_ff.ptr + 8'h01;
          end
        end
        I_RDAT: if (fall) begin
          if (s_ff.n == 4'h7) begin
            nxt_s.st = I_RACK;
            nxt_s.n = '0;
            nxt_s.oe_n = 1'b1;
          end else begin
            nxt_s.sh = {s_ff.sh[6:0], 1'b1};
            nxt_s.oe_n = s_ff.sh[6];
            nxt_s.n = s_ff.n + 4'h1;
          end
        end
        I_RACK: begin
          if (rise) begin
            nxt_s.nack = sda;
          end else if (fall) begin
            nxt_s.st = s_ff.nack ? I_IDLE : I_RDAT;
            if (!s_ff.nack) begin
              nxt_s.sh = rdata;
              nxt_s.oe_n = rdata[7];
              nxt_s.ptr = s_ff.ptr + 8'h01;
            end
          end
        end
        default: nxt_s.st = I_IDLE;
      endcase
    end
  end
  // state register; the line is released under reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.oe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign ptr = s_ff.ptr;
  assign wr = s_ff.wr;
  assign wa = s_ff.wa;
  assign wd = s_ff.wd;
  assign sda_oe_n = s_ff.oe_n;
endmodule // i2c_target

// ---- hw/amp_ctrl.sv ----
// amplifier ac diagnostic sequencing, protection and status registers
`timescale 1ns/1ps
`include "amp_map.svh"
module amp_ctrl import amp_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h35,
  parameter int RETRY_CYCLES = `T_RETRY_MS * 1000 * `T_CLK_MHZ,
  parameter int DIAG_CYCLES = `T_DIAG_US * `T_CLK_MHZ
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PWM_CLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic [1:0] OVER_SHUTDOWN,
  input wire logic [1:0] DC_OFFSET,
  input wire logic [1:0] LOAD_FAULT,
  input wire logic [1:0] PWM_FULL,
  input wire logic [1:0] OVER_LIMIT,
  input wire logic AC_DONE,
  input wire logic [15:0] AC_PHASE,
  input wire logic [15:0] AC_STIM,
  output logic [1:0] PULSE_CUT,
  output logic LIMIT_LEVEL,
  output logic [1:0] CH_HIZ,
  output logic [1:0] DIAG_RUN,
  output logic AC_RUN,
  output logic AC_LOOPBACK,
  output logic AC_CH2,
  output logic PAR_BRIDGE,
  output logic FAULT_N,
  output logic WARN_N
);
  localparam int CW = $clog2(RETRY_CYCLES + DIAG_CYCLES + 1);
  localparam logic [CW-1:0] RETRY_END = CW'(RETRY_CYCLES - 1);
  localparam logic [CW-1:0] DIAG_END = CW'(DIAG_CYCLES - 1);
  // whole state of the reference-clock side
  typedef struct packed {
    logic [7:0] ocfg;
    logic [7:0] ctl1;
    logic [7:0] acen;
    logic [7:0] acloop;
    logic [7:0] ctl3;
    logic [7:0] win;
    logic [15:0] phase;
    logic [15:0] stim;
    ac_st_t ac;
    ch_st_t [1:0] ch;
    logic [1:0][CW-1:0] cnt;
    logic [1:0][7:0] clipcnt;
    logic [1:0] oc;
    logic [1:0] dc;
    logic [1:0] ilim;
    logic [1:0] clipl;
    logic [1:0] tgl_d;
    logic [1:0] lim_d;
    logic por;
    logic clr;
  } st_t;
  st_t s_ff;
  st_t nxt_s;
  // whole state of the pwm-clock side
  typedef struct packed {
    logic [1:0] tgl;
    logic [1:0] nf;
    logic [1:0] cut;
  } pw_t;
  pw_t p_ff;
  pw_t nxt_p;
  logic scl_s; // synchronised bus clock
  logic sda_s; // synchronised bus data
  logic [1:0] oc_s; // overcurrent shutdown request
  logic [1:0] dc_s; // dc offset over threshold
  logic [1:0] lf_s; // load fault seen by dc diagnostics
  logic [1:0] full_p; // full duty, pwm side
  logic [1:0] lim_p; // over current limit, pwm side
  logic [1:0] x_tgl; // full-cycle toggles, crossed over
  logic [1:0] x_nf; // not-full level, crossed over
  logic [1:0] x_lim; // current limit level, crossed over
  logic [1:0] full_ev; // one full duty pwm cycle seen
  logic [1:0] ilim_ev; // current limit onset
  logic [1:0] clip_ind; // clip indication per channel
  logic [7:0] ptr; // register pointer of the bus
  logic wr; // write strobe from the bus
  logic [7:0] wa; // write address
  logic [7:0] wd; // write data
  logic [7:0] rdata; // read data for the pointer
  // pin inputs of the reference domain
  sync2 #(.W(8)) u_pin_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .d({SCL, SDA_IN, OVER_SHUTDOWN, DC_OFFSET, LOAD_FAULT}),
    .q({scl_s, sda_s, oc_s, dc_s, lf_s})
  );
  // pin inputs of the pwm domain
  sync2 #(.W(4)) u_pwm_sync (
    .clk(PWM_CLK),
    .rst(RESET),
    .d({PWM_FULL, OVER_LIMIT}),
    .q({full_p, lim_p})
  );
  // pwm-side flops crossing into the reference domain
  sync2 #(.W(6)) u_cross (
    .clk(REF_CLK),
    .rst(RESET),
    .d({p_ff.tgl, p_ff.nf, p_ff.cut}),
    .q({x_tgl, x_nf, x_lim})
  );
  // register bus target
  i2c_target #(.ADDR(DEV_ADDR)) u_bus (
    .clk(REF_CLK),
    .rst(RESET),
    .scl(scl_s),
    .sda(sda_s),
    .rdata(rdata),
    .ptr(ptr),
    .wr(wr),
    .wa(wa),
    .wd(wd),
    .sda_oe_n(SDA_OE_N)
  );
  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  // pwm side: cut pulses, flag full cycles per channel
  always_comb begin
    nxt_p.cut = lim_p;
    nxt_p.nf = ~full_p;
    nxt_p.tgl = p_ff.tgl ^ full_p;
  end
  // pwm side registers
  always_ff @(posedge PWM_CLK or posedge RESET) begin
    if (RESET) begin
      p_ff <= '0;
    end else begin
      p_ff <= nxt_p;
    end
  end
  // events decoded after the crossing
  assign full_ev = x_tgl ^ s_ff.tgl_d;
  assign ilim_ev = x_lim & ~s_ff.lim_d;
  // reference side: registers, ac sequencer, channels, clip
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tgl_d = x_tgl;
    nxt_s.lim_d = x_lim;
    // clear-fault bit is a one-cycle pulse, never stored
    nxt_s.clr = wr && (wa == `A_CTRL3) && wd[`B_CLEAR];
    if (wr) begin
      case (wa)
        `A_OUT_CFG: nxt_s.ocfg = wd;
        `A_CTRL1: nxt_s.ctl1 = wd;
        `A_ACEN: nxt_s.acen = wd;
        `A_ACLOOP: nxt_s.acloop = wd;
        `A_CTRL3: nxt_s.ctl3 = {1'b0, wd[6:0]};
        `A_CLIPWIN: nxt_s.win = wd;
        default: ;
      endcase
    end
    // ac pass: runs once per setting of the sensing-loop bit
    unique case (s_ff.ac)
      AC_IDLE: begin
        if (s_ff.acen[`B_SENSE]) begin
          nxt_s.ac = amp_pkg::AC_RUN;
        end
      end
      amp_pkg::AC_RUN: begin
        if (AC_DONE) begin
          nxt_s.phase = AC_PHASE;
          if (!s_ff.acloop[`B_LOOPBACK]) begin
            nxt_s.stim = AC_STIM;
          end
          nxt_s.ac = AC_HOLD;
        end
      end
      AC_HOLD: begin
        // waits for the host to drop the sensing-loop bit
        if (!s_ff.acen[`B_SENSE]) begin
          nxt_s.ac = AC_IDLE;
        end
      end
      default: nxt_s.ac = AC_IDLE;
    endcase
    // power-on warning until the first clear
    nxt_s.por = s_ff.por & ~s_ff.clr;
    for (int i = 0; i < 2; i++) begin
      // sticky flags: clear first so a same-cycle set wins
      if (s_ff.clr) begin
        nxt_s.oc[i] = 1'b0;
        nxt_s.dc[i] = 1'b0;
        nxt_s.ilim[i] = 1'b0;
        nxt_s.clipl[i] = 1'b0;
      end
      nxt_s.ilim[i] = nxt_s.ilim[i] | ilim_ev[i];
      // consecutive full-duty cycles
      if (x_nf[i]) begin
        nxt_s.clipcnt[i] = '0;
      end else if (full_ev[i] && s_ff.clipcnt[i] != 8'hFF) begin
        nxt_s.clipcnt[i] = s_ff.clipcnt[i] + 8'h01;
      end
      if (s_ff.clipcnt[i] != 8'h00 && s_ff.clipcnt[i] >= s_ff.win) begin
        nxt_s.clipl[i] = 1'b1;
      end
      // channel protection state
      nxt_s.cnt[i] = s_ff.cnt[i] + 1'b1;
      unique case (s_ff.ch[i])
        CH_PLAY: begin
          if (oc_s[i] || dc_s[i]) begin
            nxt_s.ch[i] = CH_FLT;
            nxt_s.oc[i] = oc_s[i] | s_ff.oc[i];
            nxt_s.dc[i] = dc_s[i] | s_ff.dc[i];
          end
        end
        CH_FLT: begin
          if (s_ff.clr) begin
            nxt_s.cnt[i] = '0;
            nxt_s.ch[i] = s_ff.ctl3[`B_DIAG_EN] ? CH_DIAG : CH_PLAY;
          end
        end
        CH_DIAG: begin
          if (s_ff.cnt[i] == DIAG_END) begin
            nxt_s.cnt[i] = '0;
            nxt_s.ch[i] = lf_s[i] ? CH_WAIT : CH_PLAY;
          end
        end
        CH_WAIT: begin
          if (s_ff.cnt[i] == RETRY_END) begin
            nxt_s.cnt[i] = '0;
            nxt_s.ch[i] = CH_DIAG;
          end
        end
      endcase
    end
  end
  // reference side registers
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s_ff <= '0;
      s_ff.ctl3 <= `R_CTRL3;
      s_ff.win <= `R_CLIPWIN;
      s_ff.por <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
  // clip indication: latched or following the duty directly
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      clip_ind[i] = s_ff.ctl3[`B_CLIP_NONLATCH] ? (s_ff.clipcnt[i] != 8'h00)
        : s_ff.clipl[i];
    end
  end
  // register read mux
  always_comb begin
    case (ptr)
      `A_OUT_CFG: rdata = s_ff.ocfg;
      `A_CTRL1: rdata = s_ff.ctl1;
      `A_CHSTATE: rdata = {3'b000, AC_RUN, s_ff.ch[1], s_ff.ch[0]};
      `A_FAULT: rdata = {4'h0, s_ff.dc, s_ff.oc};
      `A_CLIPST: rdata = {6'h00, clip_ind};
      `A_ACEN: rdata = s_ff.acen;
      `A_ACLOOP: rdata = s_ff.acloop;
      `A_PH_HI: rdata = s_ff.phase[15:8];
      `A_PH_LO: rdata = s_ff.phase[7:0];
      `A_ST_HI: rdata = s_ff.stim[15:8];
      `A_ST_LO: rdata = s_ff.stim[7:0];
      `A_CTRL3: rdata = s_ff.ctl3;
      `A_CLIPWIN: rdata = s_ff.win;
      `A_ILIM: rdata = {6'h00, s_ff.ilim};
      default: rdata = 8'h00;
    endcase
  end
  // outputs
  assign PULSE_CUT = p_ff.cut;
  assign LIMIT_LEVEL = s_ff.ctl1[`B_LIM_LVL];
  assign AC_RUN = s_ff.ac == amp_pkg::AC_RUN;
  assign AC_LOOPBACK = s_ff.acloop[`B_LOOPBACK];
  // reference pass always on channel one
  assign AC_CH2 = s_ff.acen[`B_SENSE_CH2] & ~s_ff.acloop[`B_LOOPBACK];
  // cleared bits fall back to bridge mode without standby
  assign PAR_BRIDGE = &s_ff.ocfg[1:0];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      CH_HIZ[i] = s_ff.ch[i] != CH_PLAY;
      DIAG_RUN[i] = s_ff.ch[i] == CH_DIAG;
    end
  end
  assign FAULT_N = !((|s_ff.oc) || ((|s_ff.dc) && !s_ff.ctl3[`B_DC_MASK]));
  assign WARN_N = !(s_ff.por || ((|clip_ind) && !s_ff.ctl3[`B_CLIP_MASK]) ||
    ((|s_ff.ilim) && !s_ff.ctl3[`B_ILIM_MASK]));
  // checks on the reference domain
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_fault_hold;
    !FAULT_N && !s_ff.clr && !wr |=> !FAULT_N;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault released early");
  property p_oc_off;
    s_ff.ch[0] == CH_PLAY && oc_s[0] |=> CH_HIZ[0] && s_ff.oc[0] ##0 !FAULT_N;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent not handled");
  property p_ilim;
    ilim_ev[1] && !s_ff.ctl3[`B_ILIM_MASK] |=> s_ff.ilim[1] && !WARN_N &&
      s_ff.ch[1] == $past(s_ff.ch[1]);
  endproperty
  a_ilim: assert property (p_ilim) else $error("limit warning missing");
  property p_clip_latch;
    !s_ff.ctl3[`B_CLIP_NONLATCH] && s_ff.clipcnt[0] != 8'h00 &&
      s_ff.clipcnt[0] >= s_ff.win |=> clip_ind[0];
  endproperty
  a_clip_latch: assert property (p_clip_latch) else $error("clip not latched");
  property p_clip_follow;
    s_ff.ctl3[`B_CLIP_NONLATCH] && x_nf[0] ##1 s_ff.ctl3[`B_CLIP_NONLATCH] |-> !clip_ind[0];
  endproperty
  a_clip_follow: assert property (p_clip_follow) else $error("clip stuck");
  property p_ac_store;
    AC_RUN && AC_DONE |=> s_ff.phase == $past(AC_PHASE) && s_ff.ac == AC_HOLD;
  endproperty
  a_ac_store: assert property (p_ac_store) else $error("phase not stored");
  property p_ref_stim;
    AC_RUN && AC_DONE && AC_LOOPBACK |=> $stable(s_ff.stim);
  endproperty
  a_ref_stim: assert property (p_ref_stim) else $error("stimulus overwritten");
  property p_restart;
    s_ff.ch[0] == CH_DIAG && s_ff.cnt[0] == DIAG_END && !lf_s[0] |=> s_ff.ch[0] == CH_PLAY;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_hold_pass;
    s_ff.ac == AC_HOLD && s_ff.acen[`B_SENSE] ##1 s_ff.acen[`B_SENSE]
      |-> (s_ff.ac == AC_HOLD) [*2];
  endproperty
  a_hold_pass: assert property (p_hold_pass) else $error("pass rearmed");
  property p_ref_ch1;
    AC_LOOPBACK |-> !AC_CH2;
  endproperty
  a_ref_ch1: assert property (p_ref_ch1) else $error("reference on ch2");
  c_ac_done: cover property (AC_RUN && AC_DONE);
  c_oc: cover property (s_ff.ch[0] == CH_FLT ##1 s_ff.clr);
  c_clip: cover property (!WARN_N && clip_ind[0]);
endmodule // amp_ctrl

// ---- tb/i2c_host.sv ----
// two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
module i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // bus idles released, pulled high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // wait n system clocks, then step off the edge
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data edge with clock high: a=1 gives start, a=0 gives stop
  task automatic ed(input logic a);
    q(3);
    sda_m = a;
    q(10);
    scl = 1'b1;
    q(10);
    sda_m = ~a;
    q(10);
  endtask
  // one bit: data set in the low phase, wire sampled at the end of the high phase
  task automatic bt(input logic b, output logic r);
    q(3);
    sda_m = b;
    q(10);
    scl = 1'b1;
    q(10);
    r = sda;
    scl = 1'b0;
  endtask
  // one byte out, msb first; returns the acknowledge seen on the wire
  task automatic xb(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(b[i], r);
    end
    bt(1'b1, ack);
  endtask
  // one byte in; the last one is answered with a not-acknowledge
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, d[i]);
    end
    bt(last, r);
  endtask
  // register write: address, pointer, data; ok when all were acknowledged
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [2:0] k;
    ed(1'b1);
    scl = 1'b0;
    xb(8'h6A, k[0]);
    xb(a, k[1]);
    xb(d, k[2]);
    ed(1'b0);
    ok = (k === 3'b000);
  endtask
  // read n bytes from pointer a, first byte ends up highest in d
  task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d, output logic ok);
    logic [2:0] k;
    logic [7:0] b;
    ed(1'b1);
    scl = 1'b0;
    xb(8'h6A, k[0]);
    xb(a, k[1]);
    ed(1'b0);
    ed(1'b1);
    scl = 1'b0;
    xb(8'h6B, k[2]);
    d = 32'h0;
    for (int i = 0; i < n; i++) begin
      rb(i == n - 1, b);
      d = {d[23:0], b};
    end
    ed(1'b0);
    ok = (k === 3'b000);
  endtask
endmodule // i2c_host

// ---- tb/amp_ctrl_tb.sv ----
// self-checking bench for the amplifier control block
`timescale 1ns/1ps
module amp_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pclk, acd = 1'b0;
  logic scl, sda_m, sda_out, sda_oe_n, lvl, acrun, aclb, ach2, pbr, fault_n, warn_n;
  logic [1:0] osd = 2'h0, dco = 2'h0, lf = 2'h0, pfull = 2'h0, olim = 2'h0;
  logic [1:0] pcut, hiz, drun;
  logic [15:0] acph = 16'h0, acst = 16'h0;
  int compares = 0;
  int miscompares = 0;
  // open-drain wire: device pulls low when its enable is low
  wire logic sda = sda_m & (sda_oe_n | sda_out);
  // watched outputs, indexed by the wait task
  wire logic [8:0] mon = {warn_n, fault_n, acrun, drun, hiz, pcut};
  amp_ctrl #(.RETRY_CYCLES(200), .DIAG_CYCLES(100)) u_amp_ctrl (
    .REF_CLK(clk), .RESET(rst), .PWM_CLK(pclk), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .OVER_SHUTDOWN(osd), .DC_OFFSET(dco),
    .LOAD_FAULT(lf), .PWM_FULL(pfull), .OVER_LIMIT(olim), .AC_DONE(acd),
    .AC_PHASE(acph), .AC_STIM(acst), .PULSE_CUT(pcut), .LIMIT_LEVEL(lvl),
    .CH_HIZ(hiz), .DIAG_RUN(drun), .AC_RUN(acrun), .AC_LOOPBACK(aclb),
    .AC_CH2(ach2), .PAR_BRIDGE(pbr), .FAULT_N(fault_n), .WARN_N(warn_n)
  );
  i2c_host u_i2c_host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // system clock 100 MHz
  always #5 clk = ~clk;
  // link clock 80 ns, offset from the system clock
  initial begin
    pclk = 1'b0;
    #3;
    forever #40 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ww(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_i2c_host.wr(a, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic rr(input logic [7:0] a, input int n, input logic [31:0] e);
    logic ok;
    logic [31:0] d;
    u_i2c_host.rd(a, n, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk(d, e);
  endtask
  // bounded wait for a watched output; a timeout is a mismatch and ends the run
  task automatic wt(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[b] !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, mon[b]}, {31'h0, v});
    if (mon[b] !== v) end_of_test();
  endtask
  // pass-finished pulse carrying its results
  task automatic done(input logic [15:0] p, input logic [15:0] s);
    acph = p;
    acst = s;
    acd = 1'b1;
    @(posedge clk);
    #1;
    acd = 1'b0;
  endtask
  // full duty on channel one for exactly n link cycles
  task automatic burst(input int n);
    @(posedge pclk);
    #1;
    pfull = 2'b01;
    repeat (n) @(posedge pclk);
    #1;
    pfull = 2'b00;
    repeat (40) @(posedge clk);
    #1;
  endtask
  task automatic t_ac();
    ww(8'h16, 8'h80);
    chk(aclb, 32'h1);
    ww(8'h15, 8'h09);
    wt(6, 1'b1, 20);
    chk(ach2, 32'h0);
    done(16'hA55A, 16'h1234);
    wt(6, 1'b0, 5);
    rr(8'h1B, 4, 32'hA55A0000);
    rr(8'h0F, 1, 32'h0);
    ww(8'h15, 8'h00);
    ww(8'h16, 8'h00);
    ww(8'h00, 8'h00);
    chk(pbr, 32'h0);
    ww(8'h15, 8'h09);
    wt(6, 1'b1, 20);
    chk(ach2, 32'h1);
    rr(8'h0F, 1, 32'h10);
    done(16'h3C5F, 16'hBEEF);
    rr(8'h1B, 4, 32'h3C5FBEEF);
    ww(8'h15, 8'h00);
    done(16'h0000, 16'h0000);
    rr(8'h1B, 4, 32'h3C5FBEEF);
    ww(8'h00, 8'h03);
    chk(pbr, 32'h1);
  endtask
  task automatic t_prot();
    ww(8'h21, 8'h90);
    wt(8, 1'b1, 10);
    ww(8'h01, 8'h10);
    chk(lvl, 32'h1);
    olim = 2'b10;
    wt(1, 1'b1, 60);
    chk(pcut[0], 32'h0);
    chk(hiz, 32'h0);
    wt(8, 1'b0, 20);
    chk(fault_n, 32'h1);
    rr(8'h25, 1, 32'h02);
    olim = 2'b00;
    wt(1, 1'b0, 60);
    ww(8'h21, 8'h90);
    wt(8, 1'b1, 10);
    osd = 2'b01;
    wt(2, 1'b1, 10);
    wt(7, 1'b0, 5);
    osd = 2'b00;
    rr(8'h10, 1, 32'h01);
    chk(fault_n, 32'h0);
    lf = 2'b01;
    ww(8'h21, 8'h90);
    wt(4, 1'b1, 5);
    wt(4, 1'b0, 100);
    chk(hiz[0], 32'h1);
    wt(4, 1'b1, 230);
    lf = 2'b00;
    wt(4, 1'b0, 110);
    wt(2, 1'b0, 5);
    chk(fault_n, 32'h1);
    ww(8'h21, 8'h11);
    dco = 2'b10;
    wt(3, 1'b1, 10);
    chk(fault_n, 32'h1);
    dco = 2'b00;
    ww(8'h21, 8'h81);
    wt(3, 1'b0, 10);
    ww(8'h21, 8'h10);
    dco = 2'b10;
    wt(7, 1'b0, 10);
    rr(8'h10, 1, 32'h08);
    dco = 2'b00;
    ww(8'h21, 8'h90);
    wt(3, 1'b0, 150);
  endtask
  task automatic t_clip();
    ww(8'h23, 8'h04);
    burst(3);
    chk(warn_n, 32'h1);
    burst(4);
    chk(warn_n, 32'h0);
    rr(8'h13, 1, 32'h01);
    ww(8'h21, 8'h90);
    wt(8, 1'b1, 10);
    ww(8'h21, 8'h12);
    burst(6);
    chk(warn_n, 32'h1);
    rr(8'h13, 1, 32'h01);
    ww(8'h21, 8'h94);
    pfull = 2'b01;
    wt(8, 1'b0, 60);
    pfull = 2'b00;
    wt(8, 1'b1, 60);
  endtask
  // reset, register defaults, then each scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(warn_n, 32'h0);
    chk(fault_n, 32'h1);
    rr(8'h21, 1, 32'h10);
    rr(8'h23, 1, 32'h14);
    ww(8'h1B, 8'hFF);
    rr(8'h1B, 2, 32'h0);
    rr(8'h40, 1, 32'h0);
    t_ac();
    t_prot();
    t_clip();
    end_of_test();
  end
endmodule // amp_ctrl_tb
